//--- src/time_sync_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - after reset try the antenna first, then IRIG-B if the antenna is silent
// - status indicator flashes twice repeatedly while detecting
// - lock indicator lit steadily once a source is found and running
// - status flashes three times for IRIG-B, four times for antenna
// - date and time captured on every second strobe of the chosen source
// - one full DCF77 frame per minute, minute mark is the missing pulse in second 59
// - pulse width coded output, pulse edge a few cycles after source second
// - frame holds BCD minute hour day weekday month year, leap and DST bits
// - ten-second mode gives one pulse every ten seconds
// - only channel 2 may use ten-second mode, channel 1 always DCF77
// - both channels produce DCF77 after reset
// - signed local offset in minutes added to UTC before encoding
// - daylight saving enable adds one hour on top of the offset
// - IRIG-B time takes the stored year, limited to 2002..2047
module time_sync_ctrl #(
  parameter int CYC_PER_MS = time_sync_pkg::CYC_PER_MS,
  parameter int DETECT_MS = time_sync_pkg::DETECT_MS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // smart antenna source
  input wire logic ant_pps,
  input wire logic ant_leap,
  input wire time_sync_pkg::time_t ant_time,
  // irig-b source, year field ignored
  input wire logic irig_pps,
  input wire time_sync_pkg::time_t irig_time,
  // indicators and sync outputs
  output logic stat_led,
  output logic sync_led,
  output logic [1:0] sync_out
);

  // ==========================================================
  // functions
  function automatic logic [4:0] days_in_month(input logic [3:0] m, input logic [6:0] y);
    case (m)
      4'h2: return (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
      4'h4, 4'h6, 4'h9, 4'hb: return 5'h1e;
      default: return 5'h1f;
    endcase
  endfunction

  function automatic logic [7:0] to_bcd(input logic [6:0] v);
    logic [6:0] t;
    t = v / 7'h0a;
    return {t[3:0], 4'(v - 7'(t * 7'h0a))};
  endfunction

  localparam int CYC_W = $clog2(CYC_PER_MS + 1);

  // ==========================================================
  // state
  time_sync_pkg::det_state_t state_q;
  logic src_ant_q;
  logic [1:0] ctrl_q;
  logic [10:0] offset_q;
  logic [6:0] year_q;
  logic [CYC_W-1:0] cyc_q;
  logic [15:0] det_ms_q;
  logic [10:0] blink_ms_q;
  logic [2:0] blink_idx_q;
  logic stb_q;
  logic leap_q;
  time_sync_pkg::time_t utc_q;
  logic [59:0] frame_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic stat_led_q;
  logic sync_led_q;
  logic [1:0] out_q;
  logic [7:0] pw_q [2];

  // ==========================================================
  // timebase, realigned to every second strobe
  wire run_w = (state_q == time_sync_pkg::ST_RUN);
  wire stb_w = run_w && (src_ant_q ? ant_pps : irig_pps);
  wire tick_w = (cyc_q == CYC_W'(CYC_PER_MS - 1));

  always_ff @(posedge sys_clk)
  begin
    if (rst || stb_w || tick_w)
      cyc_q <= '0;
    else
      cyc_q <= cyc_q + 1'b1;
  end

  // ==========================================================
  // source detection
  wire det_hit_w = (state_q == time_sync_pkg::ST_DET_ANT) ? ant_pps : irig_pps;
  wire det_end_w = tick_w && (det_ms_q == 16'(DETECT_MS - 1));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= time_sync_pkg::ST_DET_ANT;
      src_ant_q <= 1'b0;
      det_ms_q <= '0;
    end
    else
    begin
      unique case (state_q)
        time_sync_pkg::ST_DET_ANT, time_sync_pkg::ST_DET_IRIG:
        begin
          if (det_hit_w)
          begin
            state_q <= time_sync_pkg::ST_RUN;
            src_ant_q <= (state_q == time_sync_pkg::ST_DET_ANT);
            det_ms_q <= '0;
          end
          else if (det_end_w)
          begin
            // antenna window first, then irig, then round again
            state_q <= (state_q == time_sync_pkg::ST_DET_ANT) ?
                       time_sync_pkg::ST_DET_IRIG : time_sync_pkg::ST_DET_ANT;
            det_ms_q <= '0;
          end
          else if (tick_w)
            det_ms_q <= det_ms_q + 16'h0001;
        end
        time_sync_pkg::ST_RUN:
          state_q <= time_sync_pkg::ST_RUN;
        default:
          state_q <= time_sync_pkg::ST_DET_ANT;
      endcase
    end
  end

  // ==========================================================
  // indicators
  wire [2:0] blinks_w = !run_w ? time_sync_pkg::BLINKS_DET :
                        src_ant_q ? time_sync_pkg::BLINKS_ANT : time_sync_pkg::BLINKS_IRIG;
  wire in_gap_w = (blink_idx_q >= blinks_w);
  wire flash_end_w = (blink_ms_q >= time_sync_pkg::BLINK_ON_MS + time_sync_pkg::BLINK_OFF_MS - 11'h001);
  wire gap_end_w = (blink_ms_q >= time_sync_pkg::BLINK_GAP_MS - 11'h001);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      blink_ms_q <= '0;
      blink_idx_q <= '0;
      stat_led_q <= 1'b0;
      sync_led_q <= 1'b0;
    end
    else
    begin
      sync_led_q <= run_w;
      stat_led_q <= !in_gap_w && (blink_ms_q < time_sync_pkg::BLINK_ON_MS);
      if (tick_w)
      begin
        if ((in_gap_w && gap_end_w) || (!in_gap_w && flash_end_w))
        begin
          blink_ms_q <= '0;
          blink_idx_q <= in_gap_w ? 3'h0 : blink_idx_q + 3'h1;
        end
        else
          blink_ms_q <= blink_ms_q + 11'h001;
      end
    end
  end

  // ==========================================================
  // per-second capture
  wire [6:0] src_year_w = src_ant_q ? ant_time.year : year_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stb_q <= 1'b0;
      utc_q <= '0;
      leap_q <= 1'b0;
    end
    else
    begin
      stb_q <= stb_w;
      if (stb_w)
      begin
        utc_q <= src_ant_q ? ant_time : irig_time;
        utc_q.year <= src_year_w;
        leap_q <= src_ant_q && ant_leap;
      end
    end
  end

  // ==========================================================
  // local time of the minute the frame announces
  wire [10:0] mod_w = {6'h00, utc_q.hour} * time_sync_pkg::MIN_PER_HOUR + {5'h00, utc_q.minute};
  wire dst_w = ctrl_q[time_sync_pkg::CTRL_DST_BIT];
  wire signed [12:0] tot_w = $signed({2'h0, mod_w}) + $signed({{2{offset_q[10]}}, offset_q})
                           + (dst_w ? time_sync_pkg::DST_SHIFT : 13'sh0000)
                           + time_sync_pkg::FRAME_LEAD;
  wire under_w = tot_w[12];
  wire over_w = !tot_w[12] && (tot_w >= time_sync_pkg::MIN_PER_DAY);
  wire [12:0] wrap_w = under_w ? 13'(tot_w + time_sync_pkg::MIN_PER_DAY) :
                       over_w ? 13'(tot_w - time_sync_pkg::MIN_PER_DAY) : tot_w;
  wire [10:0] adj_w = wrap_w[10:0];
  wire [3:0] prev_mon_w = (utc_q.month == 4'h1) ? 4'hc : utc_q.month - 4'h1;
  wire [6:0] prev_year_w = (utc_q.month == 4'h1) ? utc_q.year - 7'h01 : utc_q.year;
  time_sync_pkg::time_t loc_w;

  always_comb
  begin
    loc_w = utc_q;
    loc_w.hour = 5'(adj_w / time_sync_pkg::MIN_PER_HOUR);
    loc_w.minute = 6'(adj_w % time_sync_pkg::MIN_PER_HOUR);
    if (over_w)
    begin
      loc_w.weekday = (utc_q.weekday == 3'h7) ? 3'h1 : utc_q.weekday + 3'h1;
      if (utc_q.day == days_in_month(utc_q.month, utc_q.year))
      begin
        loc_w.day = 5'h01;
        loc_w.month = (utc_q.month == 4'hc) ? 4'h1 : utc_q.month + 4'h1;
        loc_w.year = (utc_q.month == 4'hc) ? utc_q.year + 7'h01 : utc_q.year;
      end
      else
        loc_w.day = utc_q.day + 5'h01;
    end
    else if (under_w)
    begin
      loc_w.weekday = (utc_q.weekday == 3'h1) ? 3'h7 : utc_q.weekday - 3'h1;
      if (utc_q.day == 5'h01)
      begin
        loc_w.month = prev_mon_w;
        loc_w.year = prev_year_w;
        loc_w.day = days_in_month(prev_mon_w, prev_year_w);
      end
      else
        loc_w.day = utc_q.day - 5'h01;
    end
  end

  // ==========================================================
  // frame assembly, bit n goes out in second n
  wire [7:0] bcd_min_w = to_bcd({1'b0, loc_w.minute});
  wire [7:0] bcd_hour_w = to_bcd({2'h0, loc_w.hour});
  wire [7:0] bcd_day_w = to_bcd({2'h0, loc_w.day});
  wire [7:0] bcd_mon_w = to_bcd({3'h0, loc_w.month});
  wire [7:0] bcd_year_w = to_bcd(loc_w.year);
  wire par_min_w = ^bcd_min_w[6:0];
  wire par_hour_w = ^bcd_hour_w[5:0];
  wire par_date_w = ^{bcd_day_w[5:0], loc_w.weekday, bcd_mon_w[4:0], bcd_year_w};
  wire [59:0] frame_w = {1'b0, par_date_w, bcd_year_w, bcd_mon_w[4:0], loc_w.weekday,
                         bcd_day_w[5:0], par_hour_w, bcd_hour_w[5:0], par_min_w, bcd_min_w[6:0],
                         1'b1, leap_q, !dst_w, dst_w, 17'h00000};
  wire sec0_w = (utc_q.second == 6'h00);
  wire dcf_bit_w = !sec0_w && frame_q[utc_q.second];
  wire [7:0] dcf_pw_w = (utc_q.second == time_sync_pkg::DCF_NO_PULSE_SEC) ? 8'h00 :
                        dcf_bit_w ? time_sync_pkg::DCF_ONE_MS : time_sync_pkg::DCF_ZERO_MS;
  wire [7:0] ten_pw_w = ((utc_q.second % time_sync_pkg::TEN_SEC_PERIOD) == 6'h00) ?
                        time_sync_pkg::TEN_PULSE_MS : 8'h00;
  wire ch2_ten_w = ctrl_q[time_sync_pkg::CTRL_CH2_TEN_BIT];
  wire [7:0] chan_pw_w [2];
  assign chan_pw_w[0] = dcf_pw_w;
  assign chan_pw_w[1] = ch2_ten_w ? ten_pw_w : dcf_pw_w;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      frame_q <= '0;
    else if (stb_q && sec0_w)
      frame_q <= frame_w;
  end

  // ==========================================================
  // output channels
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    always_ff @(posedge sys_clk)
    begin
      if (rst)
      begin
        pw_q[c] <= '0;
        out_q[c] <= 1'b0;
      end
      else if (stb_q)
      begin
        pw_q[c] <= chan_pw_w[c];
        out_q[c] <= (chan_pw_w[c] != 8'h00);
      end
      else if (tick_w && pw_q[c] != 8'h00)
      begin
        pw_q[c] <= pw_q[c] - 8'h01;
        out_q[c] <= (pw_q[c] > 8'h01);
      end
    end
  end

  // ==========================================================
  // apb slave, answers in the first access cycle
  wire setup_w = psel && !penable;
  wire wr_w = psel && penable && pready_q && pwrite;
  wire hit_w = (paddr == time_sync_pkg::OFS_CTRL) || (paddr == time_sync_pkg::OFS_OFFSET)
            || (paddr == time_sync_pkg::OFS_YEAR) || (paddr == time_sync_pkg::OFS_STATUS)
            || (paddr == time_sync_pkg::OFS_TIME);
  wire [6:0] wr_year_w = pwdata[6:0];
  wire year_ok_w = (pwdata[31:7] == 25'h0) && (wr_year_w >= time_sync_pkg::YEAR_MIN)
                && (wr_year_w <= time_sync_pkg::YEAR_MAX);
  wire [31:0] status_w = {22'h0, utc_q.second, run_w, src_ant_q, state_q};
  wire [31:0] rd_w = (paddr == time_sync_pkg::OFS_CTRL) ? {30'h0, ctrl_q} :
                     (paddr == time_sync_pkg::OFS_OFFSET) ? {{21{offset_q[10]}}, offset_q} :
                     (paddr == time_sync_pkg::OFS_YEAR) ? {25'h0, year_q} :
                     (paddr == time_sync_pkg::OFS_STATUS) ? status_w :
                     (paddr == time_sync_pkg::OFS_TIME) ? {2'h0, loc_w[35:6]} : 32'h0;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= setup_w;
      pslverr_q <= setup_w && !hit_w;
      prdata_q <= (setup_w && !pwrite) ? rd_w : 32'h0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_q <= time_sync_pkg::RST_CTRL;
      offset_q <= time_sync_pkg::RST_OFFSET;
      year_q <= time_sync_pkg::RST_YEAR;
    end
    else if (wr_w)
    begin
      if (paddr == time_sync_pkg::OFS_CTRL)
        ctrl_q <= pwdata[1:0];
      if (paddr == time_sync_pkg::OFS_OFFSET)
        offset_q <= pwdata[10:0];
      if (paddr == time_sync_pkg::OFS_YEAR && year_ok_w)
        year_q <= wr_year_w;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign stat_led = stat_led_q;
  assign sync_led = sync_led_q;
  assign sync_out = out_q;

endmodule // time_sync_ctrl

`default_nettype wire

//--- inc/time_sync_pkg.sv
`default_nettype none
package time_sync_pkg;

  // ==========================================================
  // time carried from a source, binary fields, year from 2000
  typedef struct packed {
    logic [6:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [2:0] weekday;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } time_t;

  // ==========================================================
  // detection and run states
  typedef enum logic [1:0] {
    ST_DET_ANT = 2'b00,
    ST_DET_IRIG = 2'b01,
    ST_RUN = 2'b10
  } det_state_t;

  // ==========================================================
  // register map
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_OFFSET = 12'h004;
  localparam logic [11:0] OFS_YEAR = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam logic [11:0] OFS_TIME = 12'h010;
  localparam int CTRL_CH2_TEN_BIT = 0;
  localparam int CTRL_DST_BIT = 1;
  localparam int STAT_SRC_BIT = 2;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_SEC_POS = 4;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [10:0] RST_OFFSET = 11'h000;
  localparam logic [6:0] RST_YEAR = 7'h02;
  localparam logic [6:0] YEAR_MIN = 7'h02;
  localparam logic [6:0] YEAR_MAX = 7'h2f;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
  localparam int DETECT_MS = 3000;
  localparam logic [7:0] DCF_ZERO_MS = 8'h64;
  localparam logic [7:0] DCF_ONE_MS = 8'hc8;
  localparam logic [7:0] TEN_PULSE_MS = 8'h64;
  localparam logic [10:0] BLINK_ON_MS = 11'h0c8;
  localparam logic [10:0] BLINK_OFF_MS = 11'h0c8;
  localparam logic [10:0] BLINK_GAP_MS = 11'h3e8;
  localparam logic [2:0] BLINKS_DET = 3'h2;
  localparam logic [2:0] BLINKS_IRIG = 3'h3;
  localparam logic [2:0] BLINKS_ANT = 3'h4;

  // ==========================================================
  // time arithmetic and frame layout
  localparam logic [10:0] MIN_PER_HOUR = 11'h03c;
  localparam logic signed [12:0] MIN_PER_DAY = 13'sh05a0;
  localparam logic signed [12:0] DST_SHIFT = 13'sh003c;
  localparam logic signed [12:0] FRAME_LEAD = 13'sh0001;
  localparam logic [5:0] DCF_NO_PULSE_SEC = 6'h3b;
  localparam logic [5:0] TEN_SEC_PERIOD = 6'h0a;

endpackage

`default_nettype wire

//--- tb/time_sync_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checks
module time_sync_ctrl_sva #(
  parameter int CYC_PER_MS = 1,
  parameter int DETECT_MS = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // sources
  input wire logic ant_pps,
  input wire time_sync_pkg::time_t ant_time,
  input wire logic irig_pps,
  // outputs
  input wire logic sync_led,
  input wire logic [1:0] sync_out
);
  localparam int W0 = 100 * CYC_PER_MS;
  localparam int W1 = 200 * CYC_PER_MS;
  int hi_q;
  always_ff @(posedge sys_clk)
    hi_q <= (rst || !sync_out[0]) ? 0 : hi_q + 1;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_apb_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_lock_steady: assert property (sync_led |=> sync_led)
    else $error("lock indicator dropped");
  a_lock_cause: assert property ($rose(sync_led) |-> $past(ant_pps, 2) || $past(irig_pps, 2))
    else $error("lock without strobe");
  a_idle_unlocked: assert property (!sync_led |-> sync_out == 2'h0)
    else $error("output while unlocked");
  a_pulse_cause: assert property ($rose(sync_out[0]) |-> $past(ant_pps, 2) || $past(irig_pps, 2))
    else $error("pulse not aligned to strobe");
  a_pulse_width: assert property ($fell(sync_out[0]) |-> hi_q inside {[W0 - 3:W0 + 1], [W1 - 3:W1 + 1]})
    else $error("bad pulse width");
  a_pulse_each: assert property (ant_pps && sync_led && ant_time.second != 6'h3b |-> ##2 $rose(sync_out[0]))
    else $error("second without pulse");
  a_minute_gap: assert property (ant_pps && ant_time.second == 6'h3b |-> ##2 !$rose(sync_out[0]))
    else $error("pulse in minute gap");
  a_ten_cause: assert property ($rose(sync_out[1]) |-> $past(ant_pps, 2) || $past(irig_pps, 2))
    else $error("channel 2 pulse unaligned");
endmodule // time_sync_ctrl_sva
bind time_sync_ctrl time_sync_ctrl_sva #(.CYC_PER_MS(CYC_PER_MS), .DETECT_MS(DETECT_MS)) i_time_sync_ctrl_sva (
  .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready), .ant_pps(ant_pps),
  .ant_time(ant_time), .irig_pps(irig_pps), .sync_led(sync_led), .sync_out(sync_out));
`default_nettype wire

//--- tb/dcf_receiver.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// field device decoding one pulse line
module dcf_receiver #(
  parameter int CYC_PER_MS = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // pulse line
  input wire logic line,
  // last complete frame
  output logic [59:0] frame
);
  int hi_q;
  int gap_q;
  int idx_q;
  logic line_q;
  logic [59:0] bits_q;
  always_ff @(posedge sys_clk)
  begin
    line_q <= line;
    hi_q <= line ? hi_q + 1 : 0;
    gap_q <= (line && !line_q) ? 0 : gap_q + 1;
    if (rst)
    begin
      idx_q <= 0;
      bits_q <= '0;
      frame <= '0;
    end
    else if (line && !line_q && gap_q > 1500 * CYC_PER_MS)
    begin
      frame <= bits_q;
      idx_q <= 0;
    end
    else if (!line && line_q && idx_q < 60)
    begin
      bits_q[idx_q] <= hi_q > 150 * CYC_PER_MS;
      idx_q <= idx_q + 1;
    end
  end
endmodule // dcf_receiver
`default_nettype wire

//--- tb/tb_time_sync_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_time_sync_ctrl;
  localparam int CPM = 1;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, ant_pps, ant_leap, irig_pps, stat_led, sync_led, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] sync_out;
  logic [2:0] prev;
  logic [59:0] frame, exp60;
  time_sync_pkg::time_t t_q;
  int fails, n_checks, n1, n2, off_n, grp, grp_max;
  initial
  begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  time_sync_ctrl #(.CYC_PER_MS(CPM), .DETECT_MS(3)) i_time_sync_ctrl (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ant_pps(ant_pps), .ant_leap(ant_leap), .ant_time(t_q), .irig_pps(irig_pps),
    .irig_time(t_q), .stat_led(stat_led), .sync_led(sync_led), .sync_out(sync_out));
  dcf_receiver #(.CYC_PER_MS(CPM)) i_dcf_receiver (.sys_clk(sys_clk), .rst(rst), .line(sync_out[0]), .frame(frame));
  // ==========
  // pulse and blink counting
  always @(posedge sys_clk)
  begin
    if (sync_out[0] && !prev[0]) n1++;
    if (sync_out[1] && !prev[1]) n2++;
    if (stat_led && !prev[2])
    begin
      grp = (off_n > 600 * CPM) ? 1 : grp + 1;
      if (grp > grp_max) grp_max = grp;
    end
    off_n = stat_led ? 0 : off_n + 1;
    prev = {stat_led, sync_out};
  end
  // ==========
  // tasks
  task finish_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fails++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task tick(input logic ant, input logic [5:0] mi, input logic [5:0] se);
    @(posedge sys_clk);
    t_q.minute <= mi;
    t_q.second <= se;
    ant_pps <= ant;
    irig_pps <= !ant;
    @(posedge sys_clk);
    ant_pps <= 0;
    irig_pps <= 0;
    repeat (1000 * CPM - 2) @(posedge sys_clk);
  endtask
  function automatic logic [59:0] dcf(input logic [7:0] mi, hr, dy, wd, mo, yr, input logic dst, lp);
    return {1'b0, ^{yr, mo[4:0], wd[2:0], dy[5:0]}, yr, mo[4:0], wd[2:0], dy[5:0], ^hr[5:0], hr[5:0],
      ^mi[6:0], mi[6:0], 1'b1, lp, !dst, dst, 17'h0};
  endfunction
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    finish_test();
  end
  // ==========
  // main sequence
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, ant_pps, ant_leap, irig_pps} = '0;
    t_q = {7'h17, 4'h3, 5'h0f, 3'h3, 5'h0a, 6'h14, 6'h38};
    {fails, n_checks, n1, n2, off_n, grp, grp_max, prev} = '0;
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    apb(0, time_sync_pkg::OFS_STATUS, 0);
    chk("state", 32'h0, {30'h0, rd[1:0]});
    apb(0, time_sync_pkg::OFS_CTRL, 0);
    chk("ctrl", 32'h0, rd);
    apb(0, time_sync_pkg::OFS_YEAR, 0);
    chk("year", 32'h2, rd);
    apb(0, 12'h014, 0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1, time_sync_pkg::OFS_OFFSET, 32'h5a);
    apb(1, time_sync_pkg::OFS_CTRL, 32'h3);
    for (int s = 56; s < 60; s++) tick(1, 6'h14, 6'(s));
    apb(0, time_sync_pkg::OFS_STATUS, 0);
    chk("status", 32'he, {28'h0, rd[3:0]});
    chk("sync_led", 32'h1, {31'h0, sync_led});
    grp = 0;
    grp_max = 0;
    ant_leap <= 1;
    for (int s = 0; s < 60; s++) tick(1, 6'h15, 6'(s));
    tick(1, 6'h16, 6'h0);
    exp60 = dcf(8'h52, 8'h12, 8'h15, 8'h03, 8'h03, 8'h23, 1'b1, 1'b1);
    chk("frame_lo", exp60[31:0], frame[31:0]);
    chk("frame_hi", {4'h0, exp60[59:32]}, {4'h0, frame[59:32]});
    apb(0, time_sync_pkg::OFS_TIME, 0);
    chk("time", {2'h0, 7'h17, 4'h3, 5'h0f, 3'h3, 5'h0c, 6'h35}, rd);
    chk("ten_pulses", 32'h7, n2);
    chk("blinks_ant", 32'h4, grp_max);
    rst <= 1;
    t_q <= {7'h55, 4'hb, 5'h09, 3'h2, 5'h05, 6'h07, 6'h39};
    repeat (8) @(posedge sys_clk);
    rst <= 0;
    grp = 0;
    grp_max = 0;
    apb(1, time_sync_pkg::OFS_YEAR, 32'h2f);
    apb(1, time_sync_pkg::OFS_YEAR, 32'h30);
    apb(0, time_sync_pkg::OFS_YEAR, 0);
    chk("year_limit", 32'h2f, rd);
    repeat (1500 * CPM) @(posedge sys_clk);
    chk("blinks_det", 32'h2, grp_max);
    chk("unlocked", 32'h0, {31'h0, sync_led});
    chk("idle_out", 32'h0, {30'h0, sync_out});
    for (int s = 57; s < 60; s++) tick(0, 6'h07, 6'(s));
    apb(0, time_sync_pkg::OFS_STATUS, 0);
    chk("status_irig", 32'ha, {28'h0, rd[3:0]});
    {n1, n2, grp, grp_max} = '0;
    for (int s = 0; s < 4; s++) tick(0, 6'h08, 6'(s));
    apb(0, time_sync_pkg::OFS_TIME, 0);
    chk("time_irig", {2'h0, 7'h2f, 4'hb, 5'h09, 3'h2, 5'h05, 6'h09}, rd);
    chk("ch1_pulses", 32'h4, n1);
    chk("ch2_pulses", 32'h4, n2);
    chk("blinks_irig", 32'h3, grp_max);
    finish_test();
  end
endmodule // tb_time_sync_ctrl
`default_nettype wire
